/* shared/rdio_map.svh */
// Summary of operation
// - sample every input once per 5 ms
// - per-input polarity, normally-open by default
// - activation delay, 1 ms steps, default zero
// - drop-off delay, 1 ms steps, default zero
// - AC mode adds 30 ms release delay
// - output relays updated every 5 ms cycle
// - internal logic sees inputs one cycle later
// - direct input-to-relay mapping adds one round
// - fault relay energized only when fault-free
`ifndef RDIO_MAP_SVH
`define RDIO_MAP_SVH

`define RDIO_CLK_PERIOD_NS 100
`define RDIO_MS_NS 1000000
`define RDIO_MS_CYCLES (`RDIO_MS_NS / `RDIO_CLK_PERIOD_NS)
`define RDIO_CYCLE_MS 5
`define RDIO_AC_EXTRA_MS 30

`define RDIO_NUM_IN 3
`define RDIO_NUM_OUT 5
`define RDIO_DLY_W 21

`define RDIO_OFS_CTRL 4'h0
`define RDIO_OFS_OUT_CMD 4'h1
`define RDIO_OFS_MAP 4'h2
`define RDIO_OFS_STATUS 4'h3
`define RDIO_OFS_ACT0 4'h4
`define RDIO_OFS_DROP0 4'h8

`define RDIO_CTRL_POL_LSB 0
`define RDIO_CTRL_AC_LSB 4
`define RDIO_CTRL_FAULT_BIT 8
`define RDIO_ST_COND_LSB 0
`define RDIO_ST_LOGIC_LSB 4
`define RDIO_ST_RELAY_LSB 8
`define RDIO_ST_ENERG_BIT 16

`define RDIO_RST_CTRL 32'h0000_0000
`define RDIO_RST_OUT_CMD 32'h0000_0000
`define RDIO_RST_MAP 32'h0000_0000
`define RDIO_RST_DLY 32'h0000_0000

`endif

/* shared/rdio_pkg.sv */
package rdio_pkg;
    typedef struct packed {
        logic pol_nc;
        logic ac_en;
        logic [20:0] act_ms;
        logic [20:0] drop_ms;
    } rdio_chcfg_type;
endpackage : rdio_pkg

/* verilog/rdio_chan.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rdio_map.svh"
module rdio_chan (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ms_tick,
    input wire logic i_cyc_tick,
    input wire logic i_raw,
    input wire rdio_pkg::rdio_chcfg_type i_cfg,
    output logic o_status
);
    import rdio_pkg::*;
    logic smp_q;
    logic stat_q;
    logic [20:0] cnt_q;
    logic [20:0] dly;
    logic now;
    logic expired;

    assign now = i_raw ^ i_cfg.pol_nc;

    always_comb
    begin
        dly = i_cfg.act_ms;
        if (stat_q)
        begin
            dly = 21'(i_cfg.drop_ms + (i_cfg.ac_en ?
                21'(`RDIO_AC_EXTRA_MS) : 21'h0));
        end
    end

    assign expired = (cnt_q >= dly);

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            cnt_q <= 21'h0;
        else if (i_cyc_tick && (now == stat_q || expired))
            cnt_q <= 21'h0;
        else if (i_ms_tick && smp_q != stat_q && ~&cnt_q)
            cnt_q <= 21'(cnt_q + 21'h1);
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            smp_q <= 1'b0;
        else if (i_cyc_tick)
            smp_q <= now;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            stat_q <= 1'b0;
        else if (i_cyc_tick && now != stat_q && expired)
            stat_q <= now;
    end

    assign o_status = stat_q;
endmodule : rdio_chan
`default_nettype wire

/* verilog/rdio_top.sv */
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "rdio_map.svh"
module rdio_top #(
    parameter int MS_CYCLES = `RDIO_MS_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic [2:0] I_DIGITAL_INPUT_N,
    input wire logic [5:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic [4:0] O_OUTPUT_RELAY_N,
    output logic [2:0] O_INPUT_LOGIC,
    output logic O_FAULT_RELAY_ENERGIZE
);
    import rdio_pkg::*;

    logic [2:0] din_m_q;
    logic [2:0] din_s_q;
    logic [31:0] ms_cnt_q;
    logic ms_tick;
    logic [2:0] cyc_cnt_q;
    logic cyc_tick;
    logic [31:0] ctrl_q;
    logic [31:0] out_cmd_q;
    logic [31:0] map_q;
    logic [31:0] act_q [3];
    logic [31:0] drop_q [3];
    logic [2:0] cond;
    logic [2:0] logic_q;
    logic [4:0] relay_q;
    logic energ_q;
    logic ack_q;
    logic req;
    logic [3:0] widx;
    logic [31:0] be_mask;
    logic [31:0] rd_d;
    logic [31:0] rd_q;
    logic [31:0] status;
    logic [4:0] direct;
    rdio_chcfg_type cfg [3];

    // two-stage input synchroniser
    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            din_m_q <= 3'h0;
            din_s_q <= 3'h0;
        end
        else
        begin
            din_m_q <= I_DIGITAL_INPUT_N;
            din_s_q <= din_m_q;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            ms_cnt_q <= 32'h0;
        else if (ms_tick)
            ms_cnt_q <= 32'h0;
        else
            ms_cnt_q <= ms_cnt_q + 32'h1;
    end
    assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            cyc_cnt_q <= 3'h0;
        else if (cyc_tick)
            cyc_cnt_q <= 3'h0;
        else if (ms_tick)
            cyc_cnt_q <= 3'(cyc_cnt_q + 3'h1);
    end
    assign cyc_tick = ms_tick && (cyc_cnt_q == 3'(`RDIO_CYCLE_MS - 1));

    // per-input settings from registers
    always_comb
    begin
        for (int c = 0; c < `RDIO_NUM_IN; c++)
        begin
            cfg[c].pol_nc = ctrl_q[`RDIO_CTRL_POL_LSB + c];
            cfg[c].ac_en = ctrl_q[`RDIO_CTRL_AC_LSB + c];
            cfg[c].act_ms = act_q[c][20:0];
            cfg[c].drop_ms = drop_q[c][20:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < `RDIO_NUM_IN; g++)
        begin : gen_in
            rdio_chan u_chan (
                .i_clk(I_CLK),
                .i_resetn(I_RESETN),
                .i_ms_tick(ms_tick),
                .i_cyc_tick(cyc_tick),
                .i_raw(din_s_q[g]),
                .i_cfg(cfg[g]),
                .o_status(cond[g])
            );
        end
    endgenerate

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            logic_q <= 3'h0;
        else if (cyc_tick)
            logic_q <= cond;
    end

    always_comb
    begin
        for (int r = 0; r < `RDIO_NUM_OUT; r++)
            direct[r] = |(map_q[r*3 +: 3] & logic_q);
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            relay_q <= 5'h0;
        else if (cyc_tick)
            relay_q <= out_cmd_q[4:0] | direct;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            energ_q <= 1'b0;
        else
            energ_q <= ~ctrl_q[`RDIO_CTRL_FAULT_BIT];
    end

    // avalon slave, one wait state
    assign req = I_AVS_READ | I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = req & ~ack_q;
    assign widx = I_AVS_ADDRESS[5:2];
    assign be_mask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
        {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction : merge

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            ack_q <= 1'b0;
        else
            ack_q <= req & ~ack_q;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            ctrl_q <= `RDIO_RST_CTRL;
            out_cmd_q <= `RDIO_RST_OUT_CMD;
            map_q <= `RDIO_RST_MAP;
            for (int i = 0; i < `RDIO_NUM_IN; i++)
            begin
                act_q[i] <= `RDIO_RST_DLY;
                drop_q[i] <= `RDIO_RST_DLY;
            end
        end
        else if (I_AVS_WRITE && ack_q)
        begin
            if (widx == `RDIO_OFS_CTRL)
                ctrl_q <= merge(ctrl_q, I_AVS_WRITEDATA, be_mask)
                    & 32'h0000_0177;
            if (widx == `RDIO_OFS_OUT_CMD)
                out_cmd_q <= merge(out_cmd_q, I_AVS_WRITEDATA, be_mask)
                    & 32'h0000_001f;
            if (widx == `RDIO_OFS_MAP)
                map_q <= merge(map_q, I_AVS_WRITEDATA, be_mask)
                    & 32'h0000_7fff;
            for (int i = 0; i < `RDIO_NUM_IN; i++)
            begin
                if (widx == 4'(`RDIO_OFS_ACT0 + i))
                    act_q[i] <= merge(act_q[i], I_AVS_WRITEDATA, be_mask)
                        & 32'h001f_ffff;
                if (widx == 4'(`RDIO_OFS_DROP0 + i))
                    drop_q[i] <= merge(drop_q[i], I_AVS_WRITEDATA, be_mask)
                        & 32'h001f_ffff;
            end
        end
    end

    always_comb
    begin
        status = 32'h0;
        status[`RDIO_ST_COND_LSB +: 3] = cond;
        status[`RDIO_ST_LOGIC_LSB +: 3] = logic_q;
        status[`RDIO_ST_RELAY_LSB +: 5] = relay_q;
        status[`RDIO_ST_ENERG_BIT] = energ_q;
    end

    always_comb
    begin
        rd_d = 32'h0;
        case (widx)
            `RDIO_OFS_CTRL: rd_d = ctrl_q;
            `RDIO_OFS_OUT_CMD: rd_d = out_cmd_q;
            `RDIO_OFS_MAP: rd_d = map_q;
            `RDIO_OFS_STATUS: rd_d = status;
            4'h4, 4'h5, 4'h6: rd_d = act_q[2'(widx - `RDIO_OFS_ACT0)];
            4'h8, 4'h9, 4'ha: rd_d = drop_q[2'(widx - `RDIO_OFS_DROP0)];
            default: rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            rd_q <= 32'h0;
        else if (I_AVS_READ && !ack_q)
            rd_q <= rd_d;
    end

    assign O_AVS_READDATA = rd_q;
    assign O_OUTPUT_RELAY_N = relay_q;
    assign O_INPUT_LOGIC = logic_q;
    assign O_FAULT_RELAY_ENERGIZE = energ_q;
endmodule : rdio_top
`default_nettype wire

/* verif/rdio_sva.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rdio_map.svh"
module rdio_sva #(
    parameter int MS_CYCLES = `RDIO_MS_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [5:0] I_AVS_ADDRESS,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic [4:0] O_OUTPUT_RELAY_N,
    input wire logic [2:0] O_INPUT_LOGIC,
    input wire logic O_FAULT_RELAY_ENERGIZE
);
    localparam int PER = `RDIO_CYCLE_MS * MS_CYCLES;
    int gap_q;
    logic seen_q;
    logic wrote_q;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    // spacing of output updates
    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end
        else if ($changed(O_OUTPUT_RELAY_N) || $changed(O_INPUT_LOGIC))
        begin
            gap_q <= 0;
            seen_q <= 1'b1;
        end
        else
            gap_q <= gap_q + 1;
    end
    // control word written
    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            wrote_q <= 1'b0;
        else if (I_AVS_WRITE && !O_AVS_WAITREQUEST &&
            I_AVS_ADDRESS[5:2] == 4'h0)
            wrote_q <= 1'b1;
    end
    a_one_wait: assert property ($rose(I_AVS_READ || I_AVS_WRITE) |->
        O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST) else $error("wait state");
    a_idle_ready: assert property (!(I_AVS_READ || I_AVS_WRITE) |->
        !O_AVS_WAITREQUEST) else $error("idle wait");
    a_rdata_hold: assert property (!I_AVS_READ |=> $stable(O_AVS_READDATA))
        else $error("read data moved");
    a_relay_hold: assert property ($changed(O_OUTPUT_RELAY_N) |=>
        $stable(O_OUTPUT_RELAY_N) [*8]) else $error("relay glitch");
    a_logic_hold: assert property ($changed(O_INPUT_LOGIC) |=>
        $stable(O_INPUT_LOGIC) [*8]) else $error("logic glitch");
    a_tick_grid: assert property (($changed(O_OUTPUT_RELAY_N) ||
        $changed(O_INPUT_LOGIC)) && seen_q |-> (gap_q + 1) % PER == 0)
        else $error("update off cycle grid");
    a_energize_up: assert property (!$past(I_RESETN) |=>
        O_FAULT_RELAY_ENERGIZE) else $error("fault relay not energized");
    a_energize_cause: assert property (!O_FAULT_RELAY_ENERGIZE &&
        $past(I_RESETN) |-> wrote_q) else $error("fault relay dropped");
endmodule : rdio_sva
`default_nettype wire

/* verif/rdio_field.sv */
`timescale 1ns/1ns
`default_nettype none
module rdio_field (
    input wire logic i_clk,
    input wire logic [2:0] i_level,
    output logic [2:0] o_pin
);
    // contacts settle one clock after command
    always_ff @(posedge i_clk)
        o_pin <= i_level;
endmodule : rdio_field
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    import rdio_pkg::*;
    localparam int MS = 10;
    localparam int PER = 5 * MS;
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, wq, en;
    logic [2:0] fld = 3'h0, pin, ilog;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [3:0] be = 4'hf;
    logic [4:0] rly;
    logic [5:0] rst_adr [6] = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3c};
    int fails = 0, total_checks = 0;
    always #50 clk = ~clk;
    rdio_field fm (.i_clk(clk), .i_level(fld), .o_pin(pin));
    rdio_top #(.MS_CYCLES(MS)) dut (.I_CLK(clk), .I_RESETN(rstn),
        .I_DIGITAL_INPUT_N(pin), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq),
        .O_OUTPUT_RELAY_N(rly), .O_INPUT_LOGIC(ilog),
        .O_FAULT_RELAY_ENERGIZE(en));
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wq !== 1'b0 && n < 50);
        if (n >= 50)
            fails++;
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rdc(input string s, input logic [5:0] a,
        input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        `CHK(s, e, q & m)
    endtask : rdc
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        wt(10);
        rstn <= 1'b1;
        wt(2);
        `CHK("energize", 1'b1, en)
        for (int i = 0; i < 6; i++)
            rdc("reset value", rst_adr[i], 32'hffffffff, 32'h0);
        bus(1'b1, 6'h3c, 32'hffffffff, 4'hf);
        rdc("unmapped", 6'h3c, 32'hffffffff, 32'h0);
        bus(1'b1, 6'h04, 32'h1f, 4'h0);
        wt(PER + 4);
        `CHK("relay lanes off", 5'h00, rly)
        bus(1'b1, 6'h04, 32'h1a, 4'hf);
        wt(PER + 4);
        `CHK("relay cmd", 5'h1a, rly)
        bus(1'b1, 6'h04, 32'h0, 4'hf);
        bus(1'b1, 6'h08, 32'h1, 4'hf);
        fld <= 3'b101;
        wt(PER + 4);
        rdc("cond", 6'h0c, 32'h7, 32'h5);
        wt(PER);
        `CHK("logic", 3'b101, ilog)
        wt(PER);
        `CHK("relay map", 5'h01, rly)
        bus(1'b1, 6'h00, 32'h7, 4'hf);
        wt(PER + 4);
        rdc("nc cond", 6'h0c, 32'h7, 32'h2);
        bus(1'b1, 6'h00, 32'h0, 4'hf);
        bus(1'b1, 6'h14, 32'd12, 4'hf);
        fld <= 3'b000;
        wt(2 * PER);
        fld <= 3'b010;
        wt(2 * PER);
        rdc("act early", 6'h0c, 32'h7, 32'h0);
        fld <= 3'b000;
        wt(2 * PER);
        fld <= 3'b010;
        wt(2 * PER + 4);
        rdc("act restart", 6'h0c, 32'h7, 32'h0);
        wt(2 * PER + 4);
        rdc("act done", 6'h0c, 32'h7, 32'h2);
        bus(1'b1, 6'h00, 32'h20, 4'hf);
        fld <= 3'b000;
        wt(5 * PER);
        rdc("ac hold", 6'h0c, 32'h7, 32'h2);
        wt(3 * PER + 8);
        rdc("ac drop", 6'h0c, 32'h7, 32'h0);
        bus(1'b1, 6'h00, 32'h100, 4'hf);
        wt(4);
        `CHK("fault", 1'b0, en)
        rdc("fault st", 6'h0c, 32'h10000, 32'h0);
        bus(1'b1, 6'h00, 32'h0, 4'hf);
        wt(4);
        `CHK("fault off", 1'b1, en)
        tally_and_finish();
    end
    initial
    begin
        wt(5000);
        fails++;
        tally_and_finish();
    end
endmodule : tb
bind rdio_top rdio_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.I_CLK(I_CLK),
    .I_RESETN(I_RESETN), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_ADDRESS(I_AVS_ADDRESS), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_INPUT_LOGIC(O_INPUT_LOGIC),
    .O_OUTPUT_RELAY_N(O_OUTPUT_RELAY_N),
    .O_FAULT_RELAY_ENERGIZE(O_FAULT_RELAY_ENERGIZE));
`default_nettype wire
